// File: verilog/mao_regs.vh
// Constants for the motor amplifier output interface
`ifndef MAO_REGS_VH
`define MAO_REGS_VH
// Time figures
`define MAO_CLK_HZ 10000000
`define MAO_PWM_FREQ_MHZ 19531000
`define MAO_PWM_BITS 10
// Output format codes held by the strap capture
`define MAO_FMT_SERIAL 1'b0
`define MAO_FMT_PWM 1'b1
// PWM style codes
`define MAO_PWM_5050 1'b0
`define MAO_PWM_SIGNMAG 1'b1
// Half-scale duty for a zero command
`define MAO_PWM_HALF 10'h200
`define MAO_PWM_FULL 10'h3FF
`define MAO_ZERO_CNT 10'h000
`endif

// File: verilog/mao_pwm_channel.v
// One symmetric PWM channel with 50/50 and sign/magnitude encodings
`timescale 1ns/1ps
`include "mao_regs.vh"
module mao_pwm_channel #(
    parameter WIDTH = `MAO_PWM_BITS
)
(
    input wire sys_clk_in,
    input wire resetn_in,
    input wire [WIDTH-1:0] tri_count_in,
    input wire count_top_in,
    input wire style_in,
    input wire signed [WIDTH-1:0] command_in,
    output reg pwm_out,
    output reg sign_out
);
    reg [WIDTH-1:0] duty;
    reg [WIDTH-1:0] next_duty;
    reg [WIDTH-1:0] mag;

    // ****************************************
    // Duty encoding
    // ****************************************
    always @*
    begin
        mag = command_in[WIDTH-1] ? (~command_in + 1'b1) : command_in;
        if (style_in == `MAO_PWM_5050)
            // Offset binary: zero is half, sign moves it either side
            next_duty = {~command_in[WIDTH-1], command_in[WIDTH-2:0]};
        else
            next_duty = mag[WIDTH-1] ? `MAO_PWM_FULL : {mag[WIDTH-2:0], 1'b0};
    end

    // Duty loads only at the triangle top, so a pulse never splits mid-period
    always @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            duty <= `MAO_PWM_HALF;
            pwm_out <= 1'b0;
            sign_out <= 1'b0;
        end
        else
        begin
            if (count_top_in)
            begin
                duty <= next_duty;
                sign_out <= command_in[WIDTH-1];
            end
            pwm_out <= (tri_count_in < duty);
        end
    end
endmodule // mao_pwm_channel

// File: verilog/mao_output_interface.v
// Motor output side: amplifier selects, pulse/direction, PWM, amplifier status
// Contract
// - The amplifier joins serial traffic only while its active-low select is low.
// - The amplifier output stage stays off unless its active-low enable is low.
// - The fault output pulls low in normal running and floats on a fault.
// - Strap zero tied low makes serial amplifier output the default format.
// - Torque commands go out on the axis-two select, positions on the axis-three one.
// - In pulse-and-direction mode motion comes from pulse, direction and idle signals.
// - In pulse-and-direction mode the serial command path does not respond.
// - PWM magnitude is center-aligned, 10-bit duty, at about 19.531 kHz; the 2048-clock triangle gives 4.88 kHz at the 10 MHz default clock.
// - One 50/50 PWM output is given per motor phase.
`timescale 1ns/1ps
`include "mao_regs.vh"
module mao_output_interface #(
    parameter PHASES = 3,
    parameter WIDTH = `MAO_PWM_BITS,
    parameter CLK_HZ = `MAO_CLK_HZ
)
(
    input wire sys_clk_in,
    input wire resetn_in,
    // Strap and mode
    input wire output_format_strap0_in,
    input wire pulse_dir_mode_in,
    input wire pwm_style_in,
    // Serial command requests from the profile engine
    input wire torque_req_in,
    input wire position_req_in,
    input wire frame_done_in,
    // Amplifier side
    input wire amp_serial_select_n_in,
    input wire amp_enable_n_in,
    input wire amp_fault_in,
    input wire amp_fault_opendrain_in,
    input wire step_pulse_in,
    input wire step_dir_in,
    input wire motion_idle_flag_in,
    input wire signed [PHASES*WIDTH-1:0] phase_cmd_in,
    output reg axis2_amp_select_n_out,
    output reg axis3_amp_select_n_out,
    output reg serial_format_out,
    output reg serial_active_out,
    output reg output_stage_on_out,
    output wire amp_fault_opendrain_out,
    output reg amp_fault_opendrain_oe_out,
    output reg amp_fault_seen_out,
    output reg step_pulse_out,
    output reg step_dir_out,
    output reg motion_idle_flag_out,
    output wire [PHASES-1:0] pwm_out,
    output wire [PHASES-1:0] sign_out,
    output reg bridge_dir_out,
    output reg bridge_pwm_out
);
    // Triangle of 2*2^WIDTH steps: 10 MHz gives 4.88 kHz; faster clock gives nominal rate
    localparam [WIDTH-1:0] TOP = {WIDTH{1'b1}};

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_AX2 = 3'b010;
    localparam [2:0] ST_AX3 = 3'b100;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [WIDTH-1:0] tri_count;
    reg tri_down;
    reg strap_done;
    reg [1:0] sel_sync;
    reg [1:0] en_sync;
    reg [1:0] fault_sync;
    reg [1:0] pin_sync;
    reg [1:0] pulse_sync;
    reg [1:0] dir_sync;
    reg [1:0] idle_sync;
    reg [1:0] strap_sync;
    wire count_top;

    assign count_top = (tri_count == TOP) && !tri_down;
    // Open-drain: only ever drives low
    assign amp_fault_opendrain_out = 1'b0;

    // ****************************************
    // Input synchronisers
    // ****************************************
    always @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            sel_sync <= 2'h3;
            en_sync <= 2'h3;
            fault_sync <= 2'h0;
            pin_sync <= 2'h0;
            pulse_sync <= 2'h0;
            dir_sync <= 2'h0;
            idle_sync <= 2'h3;
        end
        else
        begin
            sel_sync <= {sel_sync[0], amp_serial_select_n_in};
            en_sync <= {en_sync[0], amp_enable_n_in};
            fault_sync <= {fault_sync[0], amp_fault_in};
            pin_sync <= {pin_sync[0], amp_fault_opendrain_in};
            pulse_sync <= {pulse_sync[0], step_pulse_in};
            dir_sync <= {dir_sync[0], step_dir_in};
            idle_sync <= {idle_sync[0], motion_idle_flag_in};
        end
    end

    // ****************************************
    // Strap capture after reset release
    // ****************************************
    // No reset on this chain: it must hold the settled strap level when reset lets go
    // Limitation: the strap has to be stable for two edges before release
    always @(posedge sys_clk_in)
    begin
        strap_sync <= {strap_sync[0], output_format_strap0_in};
    end

    always @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            strap_done <= 1'b0;
            serial_format_out <= 1'b0;
        end
        else if (!strap_done)
        begin
            strap_done <= 1'b1;
            serial_format_out <= (strap_sync[1] == `MAO_FMT_SERIAL);
        end
    end

    // ****************************************
    // Amplifier-side status
    // ****************************************
    always @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            serial_active_out <= 1'b0;
            output_stage_on_out <= 1'b0;
            amp_fault_opendrain_oe_out <= 1'b1;
            amp_fault_seen_out <= 1'b0;
            step_pulse_out <= 1'b0;
            step_dir_out <= 1'b0;
            motion_idle_flag_out <= 1'b1;
        end
        else
        begin
            serial_active_out <= !sel_sync[1] && !pulse_dir_mode_in;
            output_stage_on_out <= !en_sync[1] && !fault_sync[1];
            amp_fault_opendrain_oe_out <= !fault_sync[1];
            amp_fault_seen_out <= pin_sync[1];
            if (pulse_dir_mode_in)
            begin
                step_pulse_out <= pulse_sync[1];
                step_dir_out <= dir_sync[1];
                motion_idle_flag_out <= idle_sync[1];
            end
        end
    end

    // ****************************************
    // Select sequencer, one select at a time
    // ****************************************
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (serial_format_out && !pulse_dir_mode_in)
                begin
                    if (torque_req_in)
                        next_state = ST_AX2;
                    else if (position_req_in)
                        next_state = ST_AX3;
                end
            ST_AX2:
                if (frame_done_in)
                    next_state = ST_IDLE;
            ST_AX3:
                if (frame_done_in)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            state <= ST_IDLE;
            axis2_amp_select_n_out <= 1'b1;
            axis3_amp_select_n_out <= 1'b1;
        end
        else
        begin
            state <= next_state;
            // One-hot state keeps the two selects exclusive
            axis2_amp_select_n_out <= !next_state[1];
            axis3_amp_select_n_out <= !next_state[2];
        end
    end

    // ****************************************
    // Shared triangle counter
    // ****************************************
    always @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            tri_count <= `MAO_ZERO_CNT;
            tri_down <= 1'b0;
        end
        else if (!tri_down)
        begin
            if (tri_count == TOP)
                tri_down <= 1'b1;
            else
                tri_count <= tri_count + 1'b1;
        end
        else
        begin
            if (tri_count == `MAO_ZERO_CNT)
                tri_down <= 1'b0;
            else
                tri_count <= tri_count - 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PHASES; gi = gi + 1)
        begin : g_phase
            mao_pwm_channel #(.WIDTH(WIDTH)) u_chan (
                .sys_clk_in(sys_clk_in),
                .resetn_in(resetn_in),
                .tri_count_in(tri_count),
                .count_top_in(count_top),
                .style_in(pwm_style_in),
                .command_in(phase_cmd_in[gi*WIDTH +: WIDTH]),
                .pwm_out(pwm_out[gi]),
                .sign_out(sign_out[gi])
            );
        end
    endgenerate

    // ****************************************
    // H-bridge pair from phase 0
    // ****************************************
    always @(posedge sys_clk_in)
    begin
        if (!resetn_in)
        begin
            bridge_dir_out <= 1'b0;
            bridge_pwm_out <= 1'b0;
        end
        else if (pwm_style_in == `MAO_PWM_5050)
        begin
            bridge_dir_out <= pwm_out[0];
            bridge_pwm_out <= 1'b1;
        end
        else
        begin
            bridge_dir_out <= sign_out[0];
            bridge_pwm_out <= pwm_out[0];
        end
    end
endmodule // mao_output_interface

// File: test/mao_amp_model.sv
// Amplifier model: open-drain fault line with pull-up, select pin wiring
`timescale 1ns/1ps
module mao_amp_model
(
    input wire fault_oe_in,
    input wire fault_drv_in,
    input wire select_n_in,
    output wire fault_wire_out,
    output wire select_n_out
);
    // Released line rises to the pull-up
    assign fault_wire_out = fault_oe_in ? fault_drv_in : 1'b1;
    assign select_n_out = select_n_in;
endmodule // mao_amp_model

// File: test/mao_output_interface_props.sv
// Concurrent checks on the motor output interface ports
`timescale 1ns/1ps
module mao_output_interface_props #(
    parameter PHASES = 3
)
(
    input wire sys_clk_in,
    input wire resetn_in,
    input wire pulse_dir_mode_in,
    input wire pwm_style_in,
    input wire torque_req_in,
    input wire position_req_in,
    input wire frame_done_in,
    input wire amp_enable_n_in,
    input wire amp_fault_in,
    input wire amp_fault_opendrain_in,
    input wire step_pulse_in,
    input wire axis2_amp_select_n_out,
    input wire axis3_amp_select_n_out,
    input wire serial_format_out,
    input wire output_stage_on_out,
    input wire amp_fault_opendrain_oe_out,
    input wire amp_fault_seen_out,
    input wire step_pulse_out,
    input wire [PHASES-1:0] pwm_out,
    input wire [PHASES-1:0] sign_out,
    input wire bridge_dir_out,
    input wire bridge_pwm_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_idle;
        axis2_amp_select_n_out && axis3_amp_select_n_out && serial_format_out;
    endsequence
    sequence s_req;
        !pulse_dir_mode_in && (torque_req_in || position_req_in);
    endsequence
    property p_one_sel;
        axis2_amp_select_n_out || axis3_amp_select_n_out;
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("two selects low");
    property p_take;
        s_idle ##0 s_req |=> ($past(torque_req_in) ? !axis2_amp_select_n_out
            : (!axis3_amp_select_n_out && axis2_amp_select_n_out));
    endproperty
    a_take: assert property (p_take) else $error("request not routed");
    property p_sel_hold;
        !axis2_amp_select_n_out |=> axis2_amp_select_n_out == $past(frame_done_in);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select hold wrong");
    property p_pd_refuse;
        s_idle ##0 pulse_dir_mode_in |=> axis2_amp_select_n_out && axis3_amp_select_n_out;
    endproperty
    a_pd_refuse: assert property (p_pd_refuse) else $error("serial in pd mode");
    property p_enable;
        output_stage_on_out |-> !$past(amp_enable_n_in, 3);
    endproperty
    a_enable: assert property (p_enable) else $error("stage on while disabled");
    property p_fault_oe;
        $stable(amp_fault_in) [*4] |=> amp_fault_opendrain_oe_out == !$past(amp_fault_in);
    endproperty
    a_fault_oe: assert property (p_fault_oe) else $error("fault line drive wrong");
    property p_fault_seen;
        amp_fault_seen_out == $past(amp_fault_opendrain_in, 3);
    endproperty
    a_fault_seen: assert property (p_fault_seen) else $error("fault seen wrong");
    property p_step;
        pulse_dir_mode_in [*4] |=> step_pulse_out == $past(step_pulse_in, 3);
    endproperty
    a_step: assert property (p_step) else $error("step pulse not followed");
    property p_bridge;
        $stable(pwm_style_in) [*2] |=> ($past(pwm_style_in)
            ? (bridge_pwm_out == $past(pwm_out[0])
            && bridge_dir_out == $past(sign_out[0]))
            : (bridge_pwm_out && bridge_dir_out == $past(pwm_out[0])));
    endproperty
    a_bridge: assert property (p_bridge) else $error("bridge mapping wrong");
endmodule // mao_output_interface_props
bind mao_output_interface mao_output_interface_props #(.PHASES(PHASES)) u_props (.*);

// File: test/mao_output_interface_tb.sv
// Self-checking testbench for the motor output interface
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module mao_output_interface_tb;
    reg sys_clk_in = 0, resetn_in = 0, pd = 0, sty = 0, tq = 0, ps = 0, done = 0;
    reg en_n = 1, flt = 0, stp = 0, strap = 0;
    reg [29:0] cmd = 30'h0;
    int bad_count = 0, tests_run = 0, bh;
    int hi [3];
    wire a2, a3, fmt, act, on, od, oe, seen, sp, sd, idl, bd, bp, selw, fw;
    wire [2:0] pw, sg;
    mao_output_interface #(.PHASES(3)) DUT (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .output_format_strap0_in(strap), .pulse_dir_mode_in(pd), .pwm_style_in(sty),
        .torque_req_in(tq), .position_req_in(ps), .frame_done_in(done),
        .amp_serial_select_n_in(selw), .amp_enable_n_in(en_n), .amp_fault_in(flt),
        .amp_fault_opendrain_in(fw), .step_pulse_in(stp), .step_dir_in(stp),
        .motion_idle_flag_in(!stp), .phase_cmd_in(cmd), .axis2_amp_select_n_out(a2),
        .axis3_amp_select_n_out(a3), .serial_format_out(fmt), .serial_active_out(act),
        .output_stage_on_out(on), .amp_fault_opendrain_out(od),
        .amp_fault_opendrain_oe_out(oe), .amp_fault_seen_out(seen), .step_pulse_out(sp),
        .step_dir_out(sd), .motion_idle_flag_out(idl), .pwm_out(pw), .sign_out(sg),
        .bridge_dir_out(bd), .bridge_pwm_out(bp));
    mao_amp_model AMP (.fault_oe_in(oe), .fault_drv_in(od), .select_n_in(a2),
        .fault_wire_out(fw), .select_n_out(selw));
    initial forever #50 sys_clk_in = ~sys_clk_in;
    task tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    // Triangle 0..1023 then 1023..0: every count shows twice per 2048-clock period
    function int exp_hi(input int d);
        return 2 * d;
    endfunction
    task report_and_stop;
        if (bad_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task t_reset;
        tick(8);
        `CHK("sel2", 1'b1, a2)
        `CHK("fault_oe", 1'b1, oe)
        resetn_in = 1;
        tick(2);
        `CHK("format", 1'b1, fmt)
    endtask
    task t_frame(input bit pos);
        tq = !pos;
        ps = pos;
        tick(1);
        tq = 0;
        ps = 0;
        `CHK("sel_on", 1'b0, pos ? a3 : a2)
        `CHK("sel_other", 1'b1, pos ? a2 : a3)
        tick(4);
        `CHK("sel_stand", 1'b0, pos ? a3 : a2)
        `CHK("active", !pos, act)
        done = 1;
        tick(1);
        done = 0;
        `CHK("sel_off", 1'b1, pos ? a3 : a2)
        tick(4);
        `CHK("inactive", 1'b0, act)
    endtask
    task t_pd;
        tq = 1;
        tick(1);
        tq = 0;
        tick(3);
        pd = 1;
        tick(1);
        `CHK("pd_quiet", 1'b0, act)
        done = 1;
        tick(1);
        done = 0;
        ps = 1;
        tick(2);
        `CHK("pd_refuse", 1'b1, a3)
        ps = 0;
        stp = 1;
        tick(5);
        `CHK("step", 1'b1, sp)
        `CHK("dir", 1'b1, sd)
        `CHK("idle", 1'b0, idl)
        pd = 0;
        stp = 0;
        tick(5);
        `CHK("step_hold", 1'b1, sp)
    endtask
    task t_strap;
        strap = 1;
        resetn_in = 0;
        tick(3);
        resetn_in = 1;
        tick(2);
        `CHK("format_pwm", 1'b0, fmt)
        tq = 1;
        tick(2);
        tq = 0;
        `CHK("strap_refuse", 1'b1, a2)
        strap = 0;
        resetn_in = 0;
        tick(3);
        resetn_in = 1;
        tick(2);
        `CHK("format_back", 1'b1, fmt)
    endtask
    task t_amp;
        en_n = 0;
        tick(5);
        `CHK("stage_on", 1'b1, on)
        `CHK("fault_wire", 1'b0, fw)
        flt = 1;
        tick(6);
        `CHK("fault_float", 1'b0, oe)
        `CHK("fault_seen", 1'b1, seen)
        `CHK("stage_fault", 1'b0, on)
        flt = 0;
        en_n = 1;
        tick(6);
        `CHK("stage_off", 1'b0, on)
        `CHK("fault_drive", 1'b1, oe)
        `CHK("fault_clear", 1'b0, seen)
    endtask
    task meas;
        hi = '{0, 0, 0};
        bh = 0;
        tick(4096);
        repeat (2048)
        begin
            for (int k = 0; k < 3; k++)
                if (pw[k] === 1'b1) hi[k]++;
            if (bp === 1'b1) bh++;
            tick(1);
        end
    endtask
    task t_pwm;
        sty = 0;
        cmd = {10'h39C, 10'h064, 10'h000};
        meas;
        `CHK("duty_zero", exp_hi(512), hi[0])
        `CHK("duty_pos", exp_hi(612), hi[1])
        `CHK("duty_neg", exp_hi(412), hi[2])
        `CHK("bridge_high", 2048, bh)
        sty = 1;
        cmd[9:0] = 10'h39C;
        meas;
        `CHK("mag", exp_hi(200), hi[0])
        `CHK("mag_pos", exp_hi(200), hi[1])
        `CHK("mag_neg", exp_hi(200), hi[2])
        `CHK("bridge_mag", exp_hi(200), bh)
        `CHK("sign", 1'b1, sg[0])
        `CHK("sign_pos", 1'b0, sg[1])
        `CHK("sign_neg", 1'b1, sg[2])
        `CHK("bridge_dir", 1'b1, bd)
    endtask
    initial
    begin
        t_reset;
        t_frame(0);
        t_frame(1);
        t_pd;
        t_strap;
        t_amp;
        t_pwm;
        report_and_stop;
    end
    initial
    begin
        #5000000;
        bad_count++;
        report_and_stop;
    end
endmodule // mao_output_interface_tb
